// *** test/rx_event_source.sv ***
// detector stand-in that drives the event inputs of all four ports
`timescale 1ns/1ps
`include "rx_status_params.svh"

module rx_event_source (
   input  wire logic              core_clk,
   output rx_status_pkg::rx_evt_t evt [`NUM_PORTS]
);
   import rx_status_pkg::*;
   rx_evt_t base [`NUM_PORTS];

   initial begin
      for (int p = 0; p < `NUM_PORTS; p++) begin
         base[p] = '0;
         evt[p]  = '0;
      end
   end

   // hits last one cycle on top of the held levels
   task automatic pulse(int p, rx_evt_t v);
      @(posedge core_clk);
      evt[p] <= base[p] | v;
      @(posedge core_clk);
      evt[p] <= base[p];
   endtask

   task automatic hold(int p, rx_evt_t v);
      base[p] = v;
      @(posedge core_clk);
      evt[p] <= v;
   endtask
endmodule // rx_event_source

// *** test/rx_status_interrupt_aggregator_bench.sv ***
// self-checking bench of the receive status and interrupt aggregator
`timescale 1ns/1ps
`include "rx_status_params.svh"

module rx_status_interrupt_aggregator_bench;
   import rx_status_pkg::*;
   logic        core_clk;
   logic        nrst;
   reg_req_t    req;
   logic [7:0]  rdata;
   rx_evt_t     evt   [`NUM_PORTS];
   spare_cfg_t  spare [`NUM_PORTS];
   logic        irq_out_n;
   logic        rd_seen;
   int          n_fail;
   int          compares;
   int          seed;
   logic [7:0]  exp_q [$];
   logic [7:0]  m;
   logic [7:0]  a;
   logic [15:0] hi_lo;
   logic [15:0] care;
   rx_evt_t     v;

   rx_event_source i_rx_event_source (.core_clk(core_clk), .evt(evt));
   rx_status_interrupt_aggregator i_rx_status_interrupt_aggregator (
      .core_clk(core_clk), .nrst(nrst), .req(req), .rdata(rdata),
      .evt(evt), .spare(spare), .irq_out_n(irq_out_n));

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic idle(int n);
      @(posedge core_clk);
      req.wr <= 1'b0;
      req.rd <= 1'b0;
      repeat (n - 1) @(posedge core_clk);
   endtask

   task automatic wr(logic [1:0] p, logic [8:0] o, logic [7:0] d);
      @(posedge core_clk);
      req <= '{addr: {p, o}, wdata: d, wr: 1'b1, rd: 1'b0};
   endtask

   // the expectation is noted before the strobe so the monitor finds it
   task automatic rd(logic [1:0] p, logic [8:0] o, logic [7:0] e);
      exp_q.push_back(e);
      @(posedge core_clk);
      req <= '{addr: {p, o}, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
   endtask

   task automatic pul(int p, rx_evt_t x);
      idle(1);
      i_rx_event_source.pulse(p, x);
   endtask

   task automatic lvl(int p, rx_evt_t x);
      idle(1);
      i_rx_event_source.hold(p, x);
   endtask

   function automatic rx_evt_t ev(int k);
      rx_evt_t x;
      x = '0;
      case (k)
         0: x.ais_ci_hit = 1'b1;
         1: {x.ais_ci_hit, x.ais_present} = 2'b11;
         2: {x.rai_ci_hit, x.rai_present} = 2'b11;
         3: x.slc_align_hit = 1'b1;
         4: x.dl_full_hit = 1'b1;
         default: x.boc_valid = 1'b1;
      endcase
      return x;
   endfunction

   task automatic complete_run;
      // a read whose answer never arrived counts against the run
      if (exp_q.size() != 0)
         n_fail++;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   always @(posedge core_clk) begin
      if (rd_seen === 1'b1 && exp_q.size() > 0)
         chk("rdata", {8'h00, exp_q.pop_front()}, {8'h00, rdata});
      rd_seen <= req.rd;
   end

   initial begin
      repeat (5000) @(posedge core_clk);
      n_fail++;
      complete_run();
   end

   initial begin
      logic [8:0] ofs_t [8];
      logic [7:0] e7 [6];
      logic [3:0] lens [4];
      ofs_t = '{9'h098, 9'h099, 9'h09A, 9'h09B, 9'h09C, 9'h09D, 9'h09F,
                9'h0A0};
      e7 = '{8'h00, 8'h10, 8'h00, 8'h08, 8'h04, 8'h03};
      lens = '{4'h1, 4'h7, 4'h8, 4'h0};
      nrst = 1'b0;
      req = '0;
      rd_seen = 1'b0;
      n_fail = 0;
      compares = 0;
      seed = 32'h86266D5E;
      repeat (3) @(posedge core_clk);
      nrst <= 1'b1;
      foreach (ofs_t[i]) rd(2'd0, ofs_t[i], 8'h00);
      wr(0, 9'h0B0, 8'h04);
      wr(0, 9'h0A3, 8'h08);
      v = '0;
      v.sig_change = 32'h0102_0014;
      pul(0, v);
      idle(2);
      #1 chk("irq", 16'h0000, {15'h0000, irq_out_n});
      rd(0, 9'h09F, 8'h08);
      rd(0, 9'h098, 8'h14);
      rd(0, 9'h098, 8'h00);
      rd(0, 9'h09A, 8'h02);
      rd(0, 9'h09B, 8'h00);
      rd(0, 9'h093, 8'h08);
      rd(0, 9'h09F, 8'h00);
      idle(3);
      #1 chk("irq", 16'h0001, {15'h0000, irq_out_n});
      v.sig_change = 32'h0000_0010;
      pul(0, v);
      rd(0, 9'h093, 8'h00);
      rd(0, 9'h098, 8'h10);
      for (int k = 0; k < 6; k++) begin
         pul(3, ev(k));
         rd(3, 9'h096, e7[k]);
      end
      wr(3, 9'h0B5, 8'h02);
      pul(3, ev(2));
      rd(3, 9'h096, 8'h20);
      wr(3, 9'h0A6, 8'h04);
      pul(3, ev(4));
      idle(2);
      #1 chk("irq", 16'h0000, {15'h0000, irq_out_n});
      rd(3, 9'h09F, 8'h40);
      rd(3, 9'h096, 8'h04);
      rd(3, 9'h09F, 8'h00);
      wr(3, 9'h0B0, 8'h01);
      v = '0;
      v.sig_change = 32'h0000_0001;
      pul(3, v);
      idle(2);
      #1 chk("irq", 16'h0001, {15'h0000, irq_out_n});
      rd(3, 9'h093, 8'h08);
      rd(3, 9'h09F, 8'h00);
      wr(2, 9'h0B5, 8'h01);
      wr(2, 9'h0B4, 8'h04);
      v = '0;
      v.sa_bits = 5'h01;
      lvl(2, v);
      rd(2, 9'h096, 8'h00);
      v.sa_bits = 5'h05;
      lvl(2, v);
      rd(2, 9'h096, 8'h01);
      v = ev(1);
      v.sa6_codeword_hit = 1'b1;
      v.sig_change = 32'h0101_0001;
      pul(2, v);
      rd(2, 9'h096, 8'h02);
      rd(2, 9'h09B, 8'h01);
      rd(2, 9'h098, 8'h01);
      rd(2, 9'h09A, 8'h01);
      foreach (lens[i]) begin
         care = ~(16'hFFFF >> (lens[i] == 4'h0 ? 16 : int'(lens[i])));
         hi_lo = 16'($random(seed));
         wr(1, 9'h0B5, {lens[i], 4'h0});
         wr(1, 9'h09C, hi_lo[15:8]);
         wr(1, 9'h09D, hi_lo[7:0]);
         idle(3);
         #1 chk("care", care, spare[1].care);
         chk("pattern", hi_lo & care, spare[1].pattern);
         rd(1, 9'h09C, hi_lo[15:8]);
         rd(1, 9'h09D, hi_lo[7:0]);
      end
      v = '0;
      v.ext_pending = 3'b111;
      lvl(0, v);
      rd(0, 9'h09F, 8'h14);
      lvl(2, v);
      rd(2, 9'h09F, 8'h16);
      for (int i = 0; i < 4; i++) begin
         m = 8'($random(seed));
         a = 8'($random(seed));
         v = '0;
         v.alarm_latched = a;
         lvl(0, v);
         wr(0, 9'h0A0, m);
         rd(0, 9'h0A0, m);
         rd(0, 9'h09F, {7'h00, |(a & m)});
      end
      rd(3, 9'h0A0, 8'h00);
      idle(3);
      complete_run();
   end
endmodule // rx_status_interrupt_aggregator_bench

// *** test/rx_status_props.sv ***
// port checker of the receive status and interrupt aggregator
`timescale 1ns/1ps
`include "rx_status_params.svh"

module rx_status_props (
   input wire logic                      core_clk,
   input wire logic                      nrst,
   input wire rx_status_pkg::reg_req_t   req,
   input wire logic [7:0]                rdata,
   input wire rx_status_pkg::rx_evt_t    evt   [`NUM_PORTS],
   input wire rx_status_pkg::spare_cfg_t spare [`NUM_PORTS],
   input wire logic                      irq_out_n
);
   import rx_status_pkg::*;
   logic [3:0] e1_q;
   logic [8:0] rd_ofs_q;
   logic       rd_e1_q;
   logic       en_q;
   wire  [1:0] port = req.addr[10:9];
   wire  [8:0] ofs  = req.addr[8:0];
   wire        mask_wr = req.wr && req.wdata != 8'h00 &&
      (ofs == 9'h0A0 || ofs == 9'h0A3 || ofs == 9'h0A6);
   wire        ext = |{evt[0].ext_pending, evt[1].ext_pending,
                       evt[2].ext_pending, evt[3].ext_pending};

   ////////////////////////////////////////////////////////////////////////
   // a mask once opened stays counted as open, so the check never over-reaches
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         e1_q     <= 4'h0;
         rd_ofs_q <= 9'h1FF;
         rd_e1_q  <= 1'b0;
         en_q     <= 1'b0;
      end else begin
         if (req.wr && ofs == 9'h0B5)
            e1_q[port] <= req.wdata[0];
         rd_ofs_q <= req.rd ? ofs : 9'h1FF;
         rd_e1_q  <= e1_q[port];
         en_q     <= en_q | mask_wr | ext;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   for (genvar p = 0; p < `NUM_PORTS; p++) begin : g_port
      a_restart_on_wr: assert property (
         req.wr && req.addr == {2'(p), 9'h09C} |=> spare[p].restart)
         else $error("spare restart missing after pattern write");
      a_restart_cause: assert property (
         spare[p].restart |-> $past(req.wr) &&
            $past(req.addr) == {2'(p), 9'h09C})
         else $error("spare restart without pattern write");
      a_pattern_in_care: assert property (
         (spare[p].pattern & ~spare[p].care) == 16'h0000)
         else $error("spare pattern bit outside compare mask");
      a_lo_ignored: assert property (
         !spare[p].care[8] |-> spare[p].care[7:0] == 8'h00 &&
            spare[p].pattern[7:0] == 8'h00)
         else $error("low pattern byte used for short length");
   end

   a_summary_reserved: assert property (
      rd_ofs_q == 9'h09F |-> rdata[7] == 1'b0 && rdata[5] == 1'b0)
      else $error("reserved summary bit set");
   a_latch7_zero: assert property (
      rd_ofs_q == 9'h096 |-> rdata[7:6] == 2'b00 &&
         (!rd_e1_q || rdata[5:2] == 4'h0))
      else $error("unused sa latch bits not zero");
   a_sig4_t1_zero: assert property (
      rd_ofs_q == 9'h09B && !rd_e1_q |-> rdata == 8'h00)
      else $error("channel 25 to 32 flags set in T1");
   a_irq_needs_mask: assert property (
      !en_q |-> irq_out_n)
      else $error("interrupt raised with every mask closed");
endmodule // rx_status_props

bind rx_status_interrupt_aggregator rx_status_props i_rx_status_props (
   .core_clk(core_clk), .nrst(nrst), .req(req), .rdata(rdata),
   .evt(evt), .spare(spare), .irq_out_n(irq_out_n));

// *** verilog/event_latch.sv ***
// sticky event latch bank, a set in the clearing cycle wins
`timescale 1ns/1ps
`include "rx_status_params.svh"

module event_latch #(
   parameter int WIDTH = 8
) (
   input  wire logic             core_clk,
   input  wire logic             nrst,
   input  wire logic [WIDTH-1:0] set_i,
   input  wire logic [WIDTH-1:0] clr_i,
   output logic      [WIDTH-1:0] flag_q
);

   logic [WIDTH-1:0] flag_d;

   assign flag_d = (flag_q & ~clr_i) | set_i;

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         flag_q <= '0;
      end else begin
         flag_q <= flag_d;
      end
   end

endmodule // event_latch

// *** verilog/rx_status_interrupt_aggregator.sv ***
// receive status latches, masks and interrupt summary of four ports
`timescale 1ns/1ps
`include "rx_status_params.svh"

module rx_status_interrupt_aggregator (
   input  wire logic                    core_clk,
   input  wire logic                    nrst,
   input  wire rx_status_pkg::reg_req_t req,
   output logic [7:0]                   rdata,
   input  wire rx_status_pkg::rx_evt_t  evt   [`NUM_PORTS],
   output rx_status_pkg::spare_cfg_t    spare [`NUM_PORTS],
   output logic                         irq_out_n
);
   import rx_status_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // address decode, port index in the upper address bits
   logic [1:0]        req_port;
   logic [8:0]        req_ofs;
   logic [7:0]        rd_word  [`NUM_PORTS];
   logic [7:0]        summary  [`NUM_PORTS];
   logic [`NUM_PORTS-1:0] port_irq;
   logic [7:0]        rdata_d;
   logic [7:0]        rdata_q;
   logic              irq_n_d;
   logic              irq_n_q;

   assign req_port = req.addr[`PORT_MSB:`PORT_LSB];
   assign req_ofs  = req.addr[`OFS_MSB:0];

   genvar p;
   generate
      for (p = 0; p < `NUM_PORTS; p++) begin : g_port
         ///////////////////////////////////////////////////////////////////
         // per-port decode
         logic sel;
         logic wr_spare_hi;
         logic wr_spare_lo;
         logic wr_alarm_mask;
         logic wr_mask4;
         logic wr_mask7;
         logic wr_watch;
         logic wr_cfg;
         logic wr_en0;
         logic wr_en1;
         logic wr_en2;
         logic wr_en3;
         logic rd_l4;
         logic rd_l7;
         logic rd_s0;
         logic rd_s1;
         logic rd_s2;
         logic rd_s3;

         assign sel           = (req_port == 2'(p));
         assign wr_spare_hi   = req.wr && sel && req_ofs == `OFS_SPARE_HI;
         assign wr_spare_lo   = req.wr && sel && req_ofs == `OFS_SPARE_LO;
         assign wr_alarm_mask = req.wr && sel && req_ofs == `OFS_ALARM_MASK;
         assign wr_mask4      = req.wr && sel && req_ofs == `OFS_EVT_MASK_4;
         assign wr_mask7      = req.wr && sel && req_ofs == `OFS_EVT_MASK_7;
         assign wr_watch      = req.wr && sel && req_ofs == `OFS_SA_WATCH;
         assign wr_cfg        = req.wr && sel && req_ofs == `OFS_PORT_CFG;
         assign wr_en0        = req.wr && sel && req_ofs == `OFS_SIG_EN_0;
         assign wr_en1        = req.wr && sel && req_ofs == `OFS_SIG_EN_1;
         assign wr_en2        = req.wr && sel && req_ofs == `OFS_SIG_EN_2;
         assign wr_en3        = req.wr && sel && req_ofs == `OFS_SIG_EN_3;
         assign rd_l4         = req.rd && sel && req_ofs == `OFS_EVT_LATCH_4;
         assign rd_l7         = req.rd && sel && req_ofs == `OFS_SA_LATCH;
         assign rd_s0         = req.rd && sel && req_ofs == `OFS_SIG_CH1_8;
         assign rd_s1         = req.rd && sel && req_ofs == `OFS_SIG_CH9_16;
         assign rd_s2         = req.rd && sel && req_ofs == `OFS_SIG_CH17_24;
         assign rd_s3         = req.rd && sel && req_ofs == `OFS_SIG_CH25_32;

         ///////////////////////////////////////////////////////////////////
         // software registers
         logic [7:0]  spare_hi_q;
         logic [7:0]  spare_lo_q;
         logic [7:0]  alarm_mask_q;
         logic [7:0]  mask4_q;
         logic [7:0]  mask7_q;
         logic [7:0]  watch_q;
         logic [7:0]  cfg_q;
         logic [31:0] sig_en_q;

         always_ff @(posedge core_clk) begin
            if (!nrst) begin
               spare_hi_q   <= `RST_BYTE;
               spare_lo_q   <= `RST_BYTE;
               alarm_mask_q <= `RST_BYTE;
               mask4_q      <= `RST_BYTE;
               mask7_q      <= `RST_BYTE;
               watch_q      <= `RST_BYTE;
               cfg_q        <= `RST_BYTE;
               sig_en_q     <= `RST_WORD;
            end else begin
               if (wr_spare_hi)   spare_hi_q   <= req.wdata;
               if (wr_spare_lo)   spare_lo_q   <= req.wdata;
               if (wr_alarm_mask) alarm_mask_q <= req.wdata;
               if (wr_mask4)      mask4_q      <= req.wdata;
               if (wr_mask7)      mask7_q      <= req.wdata;
               if (wr_watch)      watch_q      <= req.wdata;
               if (wr_cfg)        cfg_q        <= req.wdata;
               if (wr_en0)        sig_en_q[7:0]   <= req.wdata;
               if (wr_en1)        sig_en_q[15:8]  <= req.wdata;
               if (wr_en2)        sig_en_q[23:16] <= req.wdata;
               if (wr_en3)        sig_en_q[31:24] <= req.wdata;
            end
         end

         logic e1_mode;
         logic esf_mode;

         assign e1_mode  = cfg_q[`CFG_E1_BIT];
         assign esf_mode = cfg_q[`CFG_ESF_BIT];

         ///////////////////////////////////////////////////////////////////
         // edge history of level inputs
         logic       boc_prev_q;
         logic [4:0] sa_prev_q;

         // the first cycle after reset may flag a change against zero
         always_ff @(posedge core_clk) begin
            if (!nrst) begin
               boc_prev_q <= 1'b0;
               sa_prev_q  <= `RST_SA;
            end else begin
               boc_prev_q <= evt[p].boc_valid;
               sa_prev_q  <= evt[p].sa_bits;
            end
         end

         ///////////////////////////////////////////////////////////////////
         // latched event sources
         logic       boc_rise;
         logic       boc_fall;
         logic       sa_change;
         logic [5:0] l7_set;
         logic [5:0] l7_flag;
         logic [31:0] sig_set;
         logic [31:0] sig_clr;
         logic [31:0] sig_flag;
         logic       cos_set;
         logic       cos_flag;

         assign boc_rise  = evt[p].boc_valid && !boc_prev_q;
         assign boc_fall  = !evt[p].boc_valid && boc_prev_q;
         assign sa_change = |((evt[p].sa_bits ^ sa_prev_q)
                              & watch_q[4:0]);

         // E1 reuses bits 1:0 for the Sa events, T1 fills bits 4:0 and bit 5 in ESF only
         assign l7_set[`L7_BOC_FOUND] = e1_mode ? sa_change
                                                : boc_rise;
         assign l7_set[`L7_BOC_GONE] = e1_mode ? evt[p].sa6_codeword_hit
                                               : boc_fall;
         assign l7_set[`L7_FDLF] = !e1_mode && evt[p].dl_full_hit;
         assign l7_set[`L7_SLC]  = !e1_mode && evt[p].slc_align_hit;
         assign l7_set[`L7_AIS_CI] = !e1_mode && evt[p].ais_ci_hit
                                     && evt[p].ais_present;
         assign l7_set[`L7_RAI_CI] = !e1_mode && esf_mode
                                     && evt[p].rai_ci_hit
                                     && evt[p].rai_present;

         event_latch #(
            .WIDTH (6)
         ) u_l7 (
            .core_clk (core_clk),
            .nrst     (nrst),
            .set_i    (l7_set),
            .clr_i    ({6{rd_l7}}),
            .flag_q   (l7_flag)
         );

         // channel 1 and 17 change inputs carry the CAS alignment and the
         // reserved/distant-multiframe bits upstream in E1 CAS mode
         assign sig_set = evt[p].sig_change
                          & (e1_mode ? `E1_CHAN_MASK
                                     : `T1_CHAN_MASK);
         assign sig_clr = {{8{rd_s3}}, {8{rd_s2}},
                           {8{rd_s1}}, {8{rd_s0}}};

         event_latch #(
            .WIDTH (32)
         ) u_sig (
            .core_clk (core_clk),
            .nrst     (nrst),
            .set_i    (sig_set),
            .clr_i    (sig_clr),
            .flag_q   (sig_flag)
         );

         assign cos_set = |(sig_set & sig_en_q);

         event_latch #(
            .WIDTH (1)
         ) u_cos (
            .core_clk (core_clk),
            .nrst     (nrst),
            .set_i    (cos_set),
            .clr_i    (rd_l4),
            .flag_q   (cos_flag)
         );

         ///////////////////////////////////////////////////////////////////
         // interrupt summary
         logic [5:0] l7_view;
         logic [7:0] l4_view;
         logic [7:0] l7_byte;
         logic       pend_alarm;
         logic       pend_l4;
         logic       pend_l7;

         assign l7_view = l7_flag & (e1_mode ? `L7_E1_READ_MASK
                                             : `L7_T1_READ_MASK);
         assign l7_byte = {2'b00, l7_view};
         assign l4_view = {4'h0, cos_flag, 3'b000};

         assign pend_alarm = |(evt[p].alarm_latched & alarm_mask_q);
         assign pend_l4    = cos_flag && mask4_q[`SIG_COS_BIT];
         assign pend_l7    = |(l7_byte & mask7_q);

         // live view, so a bit drops as soon as its last cause is cleared
         assign summary[p] = {1'b0,
                              pend_l7,
                              1'b0,
                              evt[p].ext_pending[2],
                              pend_l4,
                              evt[p].ext_pending[1],
                              e1_mode && evt[p].ext_pending[0],
                              pend_alarm};
         assign port_irq[p] = |summary[p];

         ///////////////////////////////////////////////////////////////////
         // spare-code detector setup
         logic [4:0]  len;
         logic [15:0] care;
         spare_cfg_t  spare_d;
         spare_cfg_t  spare_q;

         assign len  = (cfg_q[`CFG_LEN_MSB:`CFG_LEN_LSB] == `LEN_ZERO)
                       ? `LEN_FULL
                       : {1'b0, cfg_q[`CFG_LEN_MSB:`CFG_LEN_LSB]};
         // pattern grows from bit 7 of hi; short lengths leave lo unused
         assign care = ~(`CARE_ALL >> len);
         assign spare_d.care    = care;
         assign spare_d.pattern = {spare_hi_q, spare_lo_q} & care;
         assign spare_d.restart = wr_spare_hi;

         always_ff @(posedge core_clk) begin
            if (!nrst) begin
               spare_q <= '0;
            end else begin
               spare_q <= spare_d;
            end
         end

         assign spare[p] = spare_q;

         ///////////////////////////////////////////////////////////////////
         // read selection
         assign rd_word[p] =
            (req_ofs == `OFS_EVT_LATCH_4) ? l4_view           :
            (req_ofs == `OFS_SA_LATCH)    ? l7_byte           :
            (req_ofs == `OFS_SIG_CH1_8)   ? sig_flag[7:0]     :
            (req_ofs == `OFS_SIG_CH9_16)  ? sig_flag[15:8]    :
            (req_ofs == `OFS_SIG_CH17_24) ? sig_flag[23:16]   :
            (req_ofs == `OFS_SIG_CH25_32) ? sig_flag[31:24]   :
            (req_ofs == `OFS_SPARE_HI)    ? spare_hi_q        :
            (req_ofs == `OFS_SPARE_LO)    ? spare_lo_q        :
            (req_ofs == `OFS_IRQ_SUMMARY) ? summary[p]        :
            (req_ofs == `OFS_ALARM_MASK)  ? alarm_mask_q      :
            (req_ofs == `OFS_EVT_MASK_4)  ? mask4_q           :
            (req_ofs == `OFS_EVT_MASK_7)  ? mask7_q           :
            (req_ofs == `OFS_SIG_EN_0)    ? sig_en_q[7:0]     :
            (req_ofs == `OFS_SIG_EN_1)    ? sig_en_q[15:8]    :
            (req_ofs == `OFS_SIG_EN_2)    ? sig_en_q[23:16]   :
            (req_ofs == `OFS_SIG_EN_3)    ? sig_en_q[31:24]   :
            (req_ofs == `OFS_SA_WATCH)    ? watch_q           :
            (req_ofs == `OFS_PORT_CFG)    ? cfg_q             :
                                            `RST_BYTE;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // read data, present only in the cycle after the strobe
   assign rdata_d = req.rd ? rd_word[req_port] : `RST_BYTE;
   assign irq_n_d = ~|port_irq;

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         rdata_q <= `RST_BYTE;
         irq_n_q <= 1'b1;
      end else begin
         rdata_q <= rdata_d;
         irq_n_q <= irq_n_d;
      end
   end

   assign rdata     = rdata_q;
   assign irq_out_n = irq_n_q;

endmodule // rx_status_interrupt_aggregator

// *** verilog/rx_status_params.svh ***
// constants of the receive status and interrupt aggregator
//
// Contract
// - ais_ci_seen_flag sets per AIS-CI detection only while AIS present; host clears.
// - slc_align_event sets on valid SLC-96 alignment with SLC data ready.
// - boc_gone_event sets when a valid bit-oriented code stops being detected.
// - boc_found_event sets when a valid bit-oriented code becomes detected.
// - in E1 mode sa6_codeword_event (bit 1) sets on valid Sa6 codeword.
// - in E1 mode sa_bit_change_event (bit 0) sets on any watched Sa bit change.
// - E1 latch register flags latched and interrupting; bits 7..2 read zero.
// - one latched change flag per channel in four registers; fourth E1 only.
// - channel change also sets sig_change_event when its enable bit is set.
// - sig_change_event drives irq_out_n low only when its mask bit enables it.
// - per-channel change flag stays set until its register is read, then clears.
// - E1 CAS: bit 0 of first and third registers carry alignment and alarm.
// - any write to spare_code_pattern_hi restarts the spare-code integration period.
// - pattern starts at bit 7 of hi; for lengths 1..7 only top bits compared.
// - spare_code_pattern_lo is ignored entirely for lengths 1 to 7.
// - summary bits 0..6 flag interrupting latch registers; bit 5 reserved, bit 1 not T1.
// - a summary bit clears once no unmasked condition remains in its register.
// - masked status bits never reach the summary register.
// - rx_alarm_irq_mask: one enable per RAI/AIS/LOS/LOF detect and clear, reset 0.
// - each of four ports has its own copy at base plus 200h times port.
// - rai_ci_seen_flag sets on RAI-CI only in ESF while RAI present.
`ifndef RX_STATUS_PARAMS_SVH
`define RX_STATUS_PARAMS_SVH

`define NUM_PORTS        4
`define PORT_LSB         9
`define PORT_MSB         10
`define OFS_MSB          8

`define OFS_EVT_LATCH_4  9'h093
`define OFS_SA_LATCH     9'h096
`define OFS_SIG_CH1_8    9'h098
`define OFS_SIG_CH9_16   9'h099
`define OFS_SIG_CH17_24  9'h09A
`define OFS_SIG_CH25_32  9'h09B
`define OFS_SPARE_HI     9'h09C
`define OFS_SPARE_LO     9'h09D
`define OFS_IRQ_SUMMARY  9'h09F
`define OFS_ALARM_MASK   9'h0A0
`define OFS_EVT_MASK_4   9'h0A3
`define OFS_EVT_MASK_7   9'h0A6
`define OFS_SIG_EN_0     9'h0B0
`define OFS_SIG_EN_1     9'h0B1
`define OFS_SIG_EN_2     9'h0B2
`define OFS_SIG_EN_3     9'h0B3
`define OFS_SA_WATCH     9'h0B4
`define OFS_PORT_CFG     9'h0B5

`define RST_BYTE         8'h00
`define RST_WORD         32'h0000_0000
`define RST_LATCH7       6'h00
`define RST_SA           5'h00
`define RST_LEN          5'h00

`define CFG_E1_BIT       0
`define CFG_ESF_BIT      1
`define CFG_LEN_MSB      7
`define CFG_LEN_LSB      4
`define LEN_FULL         5'h10
`define LEN_ZERO         4'h0
`define CARE_ALL         16'hFFFF

`define SIG_COS_BIT      3
`define T1_CHAN_MASK     32'h00FF_FFFF
`define E1_CHAN_MASK     32'hFFFF_FFFF

`define L7_BOC_FOUND     0
`define L7_BOC_GONE      1
`define L7_FDLF          2
`define L7_SLC           3
`define L7_AIS_CI        4
`define L7_RAI_CI        5
`define L7_T1_READ_MASK  6'h3F
`define L7_E1_READ_MASK  6'h03

`endif

// *** verilog/rx_status_pkg.sv ***
// types shared by the receive status and interrupt aggregator
package rx_status_pkg;

   // host register port request
   typedef struct packed {
      logic [10:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } reg_req_t;

   // receive-side detector outputs of one port
   typedef struct packed {
      logic        ais_ci_hit;
      logic        ais_present;
      logic        rai_ci_hit;
      logic        rai_present;
      logic        slc_align_hit;
      logic        dl_full_hit;
      logic        boc_valid;
      logic        sa6_codeword_hit;
      logic [4:0]  sa_bits;
      logic [31:0] sig_change;
      logic [7:0]  alarm_latched;
      logic [2:0]  ext_pending;
   } rx_evt_t;

   // configuration handed to the spare-code detector
   typedef struct packed {
      logic [15:0] pattern;
      logic [15:0] care;
      logic        restart;
   } spare_cfg_t;

endpackage
